// ---- hw/cpiif_consts.svh ----
// constants for the processor interrupt pin interface
// assumes inclusion by both ends, the link monitor and the bench
`ifndef CPIIF_CONSTS_SVH
`define CPIIF_CONSTS_SVH

`define CPIIF_CTRL_ADDR      32'hff000004
`define CPIIF_CTRL_RESET     32'hff000000
`define CPIIF_ACK_ADDR       32'hfffffffc
`define CPIIF_FIELD_W        8
`define CPIIF_FIELD_MSG      0
`define CPIIF_FIELD_CTRL     2
`define CPIIF_FIELD_OFF      8'h00
`define CPIIF_FIELD_ONES     8'hff
`define CPIIF_PRIO_HI        7
`define CPIIF_PRIO_LO        3
`define CPIIF_ACK_IDLE       3'h5
`define CPIIF_SYNC_HOLD      2'h2

`endif

// ---- hw/cpiif_dev_end.sv ----
// processor end: interrupt pin decode, acknowledge sequence, dispatch
// assumes controller end on sys_clk; direct pins may be asynchronous
//
// Notes on behaviour
// - zero field zero makes pin zero message
// - control register holds four vector bytes
// - active input takes its own vector byte
// - field two zero: request and acknowledge pins
// - software sets field three all ones
// - pin one always stays a direct input, pin zero unless message mode
// - register reached by sync access at address
// - register resets to acknowledge/request default
// - input zero wins, then one, two, three
// - vector indexes the interrupt table
// - controller holds request until first acknowledge
// - acknowledge only at interruptible point
// - acknowledge latched through data and waits
// - two acknowledge cycles, five idle between
// - acknowledge address in each address state
// - higher priority served, else posted
// - synchronous sources hold each level two clocks
// - inputs synchronised, held two clocks
// - self message uses no external bus
// - control register picks interrupt method
`include "cpiif_consts.svh"
`default_nettype none
module cpiif_dev_end (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // register access port
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  // processor core side
  input  wire logic        interruptible,
  input  wire logic [4:0]  currentPriority,
  input  wire logic        selfMessage,
  output logic             svcValid,
  output logic             svcPost,
  output logic [7:0]       svcVector,
  output logic             msgRequest,
  // link
  cpiif_link_if.dev        link
);
  typedef struct packed {
    logic [3:0]                   syncA;
    logic [3:0]                   syncB;
    logic [3:0]                   prevLvl;
    logic [3:0]                   pend;
    logic [31:0]                  ctrl;
    cpiif_pkg::cpiif_dev_state_t  st;
    logic [2:0]                   gap;
    logic                         ackOe;
    logic                         addrValid;
    logic [31:0]                  addr;
    logic [31:0]                  rdata;
    logic                         svcValid;
    logic                         svcPost;
    logic [7:0]                   svcVec;
    logic                         msgReq;
  } cpiif_dev_reg_t;

  cpiif_dev_reg_t q;
  cpiif_dev_reg_t d;

  function automatic logic [7:0] fieldOf(input logic [31:0] r, input logic [1:0] idx);
    fieldOf = r[idx*`CPIIF_FIELD_W +: `CPIIF_FIELD_W];
  endfunction

  function automatic logic [1:0] firstSet(input logic [3:0] m);
    firstSet = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        firstSet = 2'(i);
      end
    end
  endfunction

  logic       msgMode;
  logic       ctrlMode;
  logic [3:0] directMask;
  logic [3:0] rise;
  logic [3:0] clr;
  logic [3:0] ready4;
  logic [1:0] idx;
  logic [7:0] vec;
  logic       deliver;

  always_comb begin
    d = q;
    d.svcValid = 1'b0;
    d.svcPost  = 1'b0;
    clr = 4'h0;
    idx = 2'h0;
    vec = 8'h0;
    deliver = 1'b0;
    d.syncA = link.pinLevel;
    d.syncB = q.syncA;
    d.prevLvl = q.syncB;
    rise = q.syncB & ~q.prevLvl;
    msgMode  = (fieldOf(q.ctrl, 2'(`CPIIF_FIELD_MSG)) == `CPIIF_FIELD_OFF);
    ctrlMode = (fieldOf(q.ctrl, 2'(`CPIIF_FIELD_CTRL)) == `CPIIF_FIELD_OFF);
    // pin one always remains direct, pin zero unless message mode
    directMask = {~ctrlMode, ~ctrlMode, 1'b1, ~msgMode};
    ready4 = q.pend & directMask;
    // message requests, self message needs no bus
    d.msgReq = (msgMode & rise[0]) | selfMessage;
    case (q.st)
      cpiif_pkg::ST_IDLE: begin
        // act only at an interruptible point
        if (interruptible) begin
          if (ready4 != 4'h0) begin
            idx = firstSet(ready4);
            clr[idx] = 1'b1;
            // vector from the input's own byte
            vec = fieldOf(q.ctrl, idx);
            deliver = 1'b1;
          end else if (ctrlMode && q.syncB[`CPIIF_FIELD_CTRL]) begin
            d.st = cpiif_pkg::ST_ADDR1;
            d.ackOe = 1'b1;
            d.addrValid = 1'b1;
            d.addr = `CPIIF_ACK_ADDR;
          end
        end
      end
      cpiif_pkg::ST_ADDR1: begin
        d.addrValid = 1'b0;
        d.addr = 32'h0;
        d.st = cpiif_pkg::ST_DATA1;
      end
      cpiif_pkg::ST_DATA1: begin
        if (link.lbReady) begin
          d.ackOe = 1'b0;
          d.gap = 3'h0;
          d.st = cpiif_pkg::ST_GAP;
        end
      end
      cpiif_pkg::ST_GAP: begin
        d.gap = q.gap + 3'h1;
        if (q.gap == `CPIIF_ACK_IDLE - 3'h1) begin
          d.st = cpiif_pkg::ST_ADDR2;
          d.ackOe = 1'b1;
          d.addrValid = 1'b1;
          d.addr = `CPIIF_ACK_ADDR;
        end
      end
      cpiif_pkg::ST_ADDR2: begin
        d.addrValid = 1'b0;
        d.addr = 32'h0;
        d.st = cpiif_pkg::ST_DATA2;
      end
      cpiif_pkg::ST_DATA2: begin
        // vector from low byte on second ready
        if (link.lbReady) begin
          d.ackOe = 1'b0;
          d.st = cpiif_pkg::ST_IDLE;
          vec = link.lbData[7:0];
          deliver = 1'b1;
        end
      end
      default: d.st = cpiif_pkg::ST_IDLE;
    endcase
    // serve now if higher, else post
    if (deliver) begin
      // vector is the interrupt table index
      d.svcVec = vec;
      if (vec[`CPIIF_PRIO_HI:`CPIIF_PRIO_LO] > currentPriority) begin
        d.svcValid = 1'b1;
      end else begin
        d.svcPost = 1'b1;
      end
    end
    // edges win over a same-cycle clear
    d.pend = ((q.pend & ~clr) | rise) & directMask;
    // register reached only at its address
    d.rdata = 32'h0;
    if (regRd && regAddr == `CPIIF_CTRL_ADDR) begin
      d.rdata = q.ctrl;
    end
    // four vector bytes written as one word
    if (regWr && regAddr == `CPIIF_CTRL_ADDR) begin
      d.ctrl = regWdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{syncA: 4'h0, syncB: 4'h0, prevLvl: 4'h0, pend: 4'h0, ctrl: `CPIIF_CTRL_RESET,
             st: cpiif_pkg::ST_IDLE, gap: 3'h0, ackOe: 1'b0, addrValid: 1'b0, addr: 32'h0,
             rdata: 32'h0, svcValid: 1'b0, svcPost: 1'b0, svcVec: 8'h0, msgReq: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign link.devAckOut  = 1'b0;
  assign link.devAckOe   = q.ackOe;
  assign link.lbAddr     = q.addr;
  assign link.lbAddrValid = q.addrValid;
  assign regRdata        = q.rdata;
  assign svcValid        = q.svcValid;
  assign svcPost         = q.svcPost;
  assign svcVector       = q.svcVec;
  assign msgRequest      = q.msgReq;
endmodule
`default_nettype wire

// ---- hw/cpiif_host_end.sv ----
// controller end: external interrupt controller and direct sources
// assumes the processor end on the same sys_clk
`include "cpiif_consts.svh"
`default_nettype none
module cpiif_host_end #(
  parameter int WAIT_STATES = 4
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // user side
  input  wire logic [3:0]  directReq,
  input  wire logic        useController,
  input  wire logic        ctrlRaise,
  input  wire logic [7:0]  ctrlVector,
  output logic             ctrlBusy,
  // link
  cpiif_link_if.host       link
);
  typedef struct packed {
    logic [3:0]                  pinQ;
    logic [3:0][1:0]             hold;
    cpiif_pkg::cpiif_host_state_t st;
    logic                        secondCyc;
    logic [7:0]                  vec;
    logic [7:0]                  waitCnt;
    logic                        ready;
    logic [31:0]                 data;
  } cpiif_host_reg_t;

  cpiif_host_reg_t q;
  cpiif_host_reg_t d;
  logic [3:0]      want;
  logic            ackLow;

  assign ackLow = ~link.pinLevel[3];

  always_comb begin
    d = q;
    d.ready = 1'b0;
    d.data  = 32'h0;
    want = directReq;
    if (useController) begin
      want[2] = (q.st == cpiif_pkg::HS_REQ);
      want[3] = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (q.hold[i] != 2'h0) begin
        d.hold[i] = q.hold[i] - 2'h1;
      end else if (want[i] != q.pinQ[i]) begin
        d.pinQ[i] = want[i];
        d.hold[i] = `CPIIF_SYNC_HOLD - 2'h1;
      end
    end
    case (q.st)
      cpiif_pkg::HS_IDLE: begin
        if (ctrlRaise && useController) begin
          d.st = cpiif_pkg::HS_REQ;
          d.vec = ctrlVector;
          d.secondCyc = 1'b0;
        end
      end
      cpiif_pkg::HS_REQ, cpiif_pkg::HS_WAIT: begin
        if (link.lbAddrValid && ackLow && link.lbAddr == `CPIIF_ACK_ADDR) begin
          d.st = cpiif_pkg::HS_WAIT;
          d.waitCnt = 8'(WAIT_STATES);
        end else if (q.st == cpiif_pkg::HS_WAIT && q.waitCnt != 8'h0) begin
          d.waitCnt = q.waitCnt - 8'h1;
          if (q.waitCnt == 8'h1) begin
            d.ready = 1'b1;
            d.data = q.secondCyc ? {24'h0, q.vec} : 32'h0;
            d.secondCyc = 1'b1;
            if (q.secondCyc) begin
              d.st = cpiif_pkg::HS_IDLE;
            end
          end
        end
      end
      default: d.st = cpiif_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{pinQ: 4'h0, hold: 8'h0, st: cpiif_pkg::HS_IDLE, secondCyc: 1'b0,
             vec: 8'h0, waitCnt: 8'h0, ready: 1'b0, data: 32'h0};
    end else begin
      q <= d;
    end
  end

  assign link.hostPinOut = q.pinQ;
  assign link.hostPin3Oe = ~useController;
  assign link.lbReady    = q.ready;
  assign link.lbData     = q.data;
  assign ctrlBusy        = (q.st != cpiif_pkg::HS_IDLE);
endmodule
`default_nettype wire

// ---- hw/cpiif_link_if.sv ----
// pins and acknowledge bus between processor end and controller end
// assumes both ends share sys_clk; pin three is pulled high when idle
`default_nettype none
interface cpiif_link_if;
  // pins driven by the controller side
  logic [3:0]  hostPinOut;
  logic        hostPin3Oe;
  // open-drain acknowledge from the processor side
  logic        devAckOut;
  logic        devAckOe;
  // resolved pin levels
  logic [3:0]  pinLevel;
  // acknowledge transaction bus
  logic [31:0] lbAddr;
  logic        lbAddrValid;
  logic        lbReady;
  logic [31:0] lbData;

  assign pinLevel[2:0] = hostPinOut[2:0];
  assign pinLevel[3]   = devAckOe ? devAckOut : (hostPin3Oe ? hostPinOut[3] : 1'b1);

  modport dev (
    input  pinLevel,
    input  lbReady,
    input  lbData,
    output devAckOut,
    output devAckOe,
    output lbAddr,
    output lbAddrValid
  );

  modport host (
    input  pinLevel,
    input  lbAddr,
    input  lbAddrValid,
    output hostPinOut,
    output hostPin3Oe,
    output lbReady,
    output lbData
  );
endinterface
`default_nettype wire

// ---- hw/cpiif_pkg.sv ----
// types shared by the two ends of the interrupt pin interface
// assumes cpiif_consts.svh is on the include path
`default_nettype none
package cpiif_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR1,
    ST_DATA1,
    ST_GAP,
    ST_ADDR2,
    ST_DATA2
  } cpiif_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_REQ,
    HS_WAIT
  } cpiif_host_state_t;
endpackage
`default_nettype wire

// ---- tb/cpiif_link_monitor.sv ----
// checker on the link between the two ends
// assumes one clock and the design's constants header
`include "cpiif_consts.svh"
`default_nettype none
module cpiif_link_monitor (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // link signals
  input wire logic [3:0]  hostPinOut,
  input wire logic        hostPin3Oe,
  input wire logic        devAckOut,
  input wire logic        devAckOe,
  input wire logic [3:0]  pinLevel,
  input wire logic [31:0] lbAddr,
  input wire logic        lbAddrValid,
  input wire logic        lbReady
);
  logic firstCyc_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      firstCyc_q <= 1'b0;
    else if (lbAddrValid)
      firstCyc_q <= ~firstCyc_q;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_ACK_ADDR: assert property (lbAddrValid |-> lbAddr == `CPIIF_ACK_ADDR)
    else $error("ack address wrong");
  AST_ADDR_IDLE: assert property (!lbAddrValid |-> lbAddr == 32'h0)
    else $error("address outside address state");
  AST_ACK_LOW: assert property (devAckOe |-> !pinLevel[3] && !devAckOut)
    else $error("ack pin not low");
  AST_ACK_START: assert property (lbAddrValid |-> devAckOe ##1 !lbAddrValid)
    else $error("address state without ack");
  AST_ACK_HOLD: assert property (devAckOe && !lbReady |=> devAckOe)
    else $error("ack dropped early");
  AST_ACK_DROP: assert property (devAckOe && lbReady |=> !devAckOe)
    else $error("ack held past ready");
  AST_ACK_GAP: assert property (lbReady && devAckOe && firstCyc_q |=> !devAckOe [*5] ##1 lbAddrValid)
    else $error("idle gap wrong");
  AST_READY_BOUND: assert property (lbAddrValid |-> ##[1:20] lbReady)
    else $error("no ready");
  AST_REQ_HOLD: assert property (!hostPin3Oe && hostPinOut[2] && !devAckOe |=> hostPinOut[2])
    else $error("request dropped early");
  cover property (lbReady && !firstCyc_q);
  cover property (lbAddrValid);
  cover property (devAckOe ##1 !devAckOe);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// bench joining processor end and controller end
// assumes design files and constants header on the include path
`include "cpiif_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] regAddr = '0, regWdata = '0, regRdata, cfg;
  logic        regWr = 1'b0, regRd = 1'b0, interruptible = 1'b0, selfMessage = 1'b0;
  logic        svcValid, svcPost, msgRequest, ctrlBusy, rdPend = 1'b0;
  logic        useController = 1'b0, ctrlRaise = 1'b0;
  logic [4:0]  currentPriority = '0;
  logic [7:0]  svcVector, ctrlVector = '0;
  logic [3:0]  directReq = '0;
  logic [8:0]  svcQ[$];
  logic [31:0] rdQ[$];
  logic        msgQ[$];
  int          mismatches = 0, cmp_count = 0;
  always #20 sys_clk = ~sys_clk;
  cpiif_link_if u_cpiif_link_if ();
  cpiif_dev_end u_cpiif_dev_end (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .interruptible(interruptible),
    .currentPriority(currentPriority), .selfMessage(selfMessage), .svcValid(svcValid), .svcPost(svcPost),
    .svcVector(svcVector), .msgRequest(msgRequest), .link(u_cpiif_link_if.dev));
  cpiif_host_end #(.WAIT_STATES(2)) u_cpiif_host_end (.sys_clk(sys_clk), .rstn(rstn), .directReq(directReq),
    .useController(useController), .ctrlRaise(ctrlRaise), .ctrlVector(ctrlVector), .ctrlBusy(ctrlBusy),
    .link(u_cpiif_link_if.host));
  cpiif_link_monitor u_cpiif_link_monitor (.sys_clk(sys_clk), .rstn(rstn),
    .hostPinOut(u_cpiif_link_if.hostPinOut), .hostPin3Oe(u_cpiif_link_if.hostPin3Oe),
    .devAckOut(u_cpiif_link_if.devAckOut), .devAckOe(u_cpiif_link_if.devAckOe),
    .pinLevel(u_cpiif_link_if.pinLevel), .lbAddr(u_cpiif_link_if.lbAddr),
    .lbAddrValid(u_cpiif_link_if.lbAddrValid), .lbReady(u_cpiif_link_if.lbReady));
  task automatic fail(input string m);
    mismatches++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [31:0] got);
    cmp_count++;
    if (rdQ.size() == 0 || got !== rdQ[0])
      fail("read data");
    if (rdQ.size() != 0)
      void'(rdQ.pop_front());
  endtask
  task automatic cmp_svc(input logic [8:0] got);
    cmp_count++;
    if (svcQ.size() == 0 || got !== svcQ[0])
      fail("service vector");
    if (svcQ.size() != 0)
      void'(svcQ.pop_front());
  endtask
  task automatic cmp_msg();
    cmp_count++;
    if (msgQ.size() == 0)
      fail("message request");
    else
      void'(msgQ.pop_front());
  endtask
  // outputs watched against the notes
  always @(posedge sys_clk) begin
    rdPend <= regRd;
    if (rdPend)
      cmp_rd(regRdata);
    if ((svcValid | svcPost) !== 1'b0)
      cmp_svc({svcPost, svcVector});
    if (msgRequest !== 1'b0)
      cmp_msg();
  end
  task automatic exp_svc(input logic [7:0] v);
    svcQ.push_back({!(v[7:3] > currentPriority), v});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask
  // pin high then low, four clocks each
  task automatic pin(input int i);
    @(posedge sys_clk);
    directReq[i] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    directReq[i] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic drain(input string t);
    int n;
    n = 0;
    while ((svcQ.size() || rdQ.size() || msgQ.size()) && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300)
      fail("result missing");
    repeat (8) @(posedge sys_clk);
    $display("test %s done", t);
  endtask
  task automatic ctrl(input logic [4:0] p);
    logic [7:0] v;
    v = 8'($urandom);
    @(posedge sys_clk);
    currentPriority <= p;
    interruptible <= 1'b0;
    ctrlRaise <= 1'b1;
    ctrlVector <= v;
    @(posedge sys_clk);
    ctrlRaise <= 1'b0;
    repeat (10) @(posedge sys_clk);
    cmp_count++;
    if (u_cpiif_link_if.devAckOe !== 1'b0) fail("ack while busy");
    cmp_count++;
    if (ctrlBusy !== 1'b1) fail("controller not busy");
    exp_svc(v);
    interruptible <= 1'b1;
    drain("controller");
    cmp_count++;
    if (ctrlBusy !== 1'b0) fail("controller still busy");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail("timeout");
    give_verdict();
  end
  initial begin
    void'($urandom(59772));
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`CPIIF_CTRL_ADDR, `CPIIF_CTRL_RESET);
    rd(32'hff000008, 32'h0);
    wr(32'hff000000, $urandom);
    rd(`CPIIF_CTRL_ADDR, `CPIIF_CTRL_RESET);
    drain("reset");
    useController <= 1'b1;
    ctrl(5'h1f);
    ctrl(5'h00);
    useController <= 1'b0;
    cfg = $urandom | 32'h01010101;
    wr(`CPIIF_CTRL_ADDR, cfg);
    rd(`CPIIF_CTRL_ADDR, cfg);
    currentPriority <= 5'($urandom);
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      exp_svc(cfg[8*i +: 8]);
      pin(i);
    end
    drain("direct");
    interruptible <= 1'b0;
    directReq <= 4'hf;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) exp_svc(cfg[8*i +: 8]);
    interruptible <= 1'b1;
    directReq <= 4'h0;
    drain("priority");
    wr(`CPIIF_CTRL_ADDR, cfg & 32'hffffff00);
    msgQ.push_back(1'b1);
    pin(0);
    exp_svc(cfg[15:8]);
    pin(1);
    msgQ.push_back(1'b1);
    selfMessage <= 1'b1;
    @(posedge sys_clk);
    selfMessage <= 1'b0;
    drain("message");
    wr(`CPIIF_CTRL_ADDR, {8'hff, 8'h00, cfg[15:0]});
    useController <= 1'b1;
    exp_svc(cfg[15:8]);
    pin(1);
    ctrl(5'($urandom));
    give_verdict();
  end
endmodule
`default_nettype wire
